// >>> rtl/wdt_pkg.sv
// Constants and types shared by the watchdog and wake-up control block
package wdt_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] WDT_CTRL_OFS = 8'h00;
  localparam logic [7:0] RST_FLAG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] WAKE_EN_OFS = 8'h0C;
  localparam logic [7:0] MODE_OFS = 8'h10;
  // watchdog_control layout and reset value
  localparam logic [7:0] WDT_CTRL_RST = 8'h53;
  localparam int KEY_LSB = 3;
  localparam logic [4:0] KEY_ENABLE = 5'h0A;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  // reset_flag_control bits
  localparam int SYSCLK_KEEP_BIT = 7;
  localparam int LV_RESET_BIT = 2;
  localparam int LV_KEY_BIT = 1;
  localparam int KEY_RESET_BIT = 0;
  // status bits
  localparam int TIMEOUT_BIT = 0;
  localparam int POWERDOWN_BIT = 1;
  localparam int HS_STABLE_BIT = 2;
  localparam int LS_STABLE_BIT = 3;
  localparam int SUB_RUN_BIT = 4;
  // mode bits
  localparam int IDLE_EN_BIT = 0;
  localparam int FAST_WAKE_BIT = 1;
  localparam int HXT_SEL_BIT = 2;
  localparam int LVD_EN_BIT = 3;
  localparam logic [3:0] MODE_RST = 4'h4;
  // Timing counts
  localparam logic [10:0] SST_CYCLES = 11'h400;
  localparam logic [1:0] KEY_RESET_TICKS = 2'h2;
  // Watchdog divider exponents for timeout select codes 0..7
  localparam int CNT_W = 18;
  localparam logic [4:0] TO_EXP [8] = '{5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};
  localparam int PORTA_W = 8;
  localparam int IRQ_W = 4;
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_HALT = 2'b01,
    PM_HS_START = 2'b10,
    PM_LS_START = 2'b11
  } pm_state_t;
endpackage : wdt_pkg

// >>> rtl/wdt_cnt_if.sv
// Control and overflow signals between the controller and the watchdog counter
`timescale 1ns/10ps
`default_nettype none
interface wdt_cnt_if;
  logic tick;
  logic enable;
  logic clear;
  logic [2:0] tsel;
  logic overflow;
  modport ctl (output tick, output enable, output clear, output tsel, input overflow);
  modport cnt (input tick, input enable, input clear, input tsel, output overflow);
endinterface : wdt_cnt_if
`default_nettype wire

// >>> rtl/sync2.sv
// Two-flop synchroniser for pins
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : sync2
`default_nettype wire

// >>> rtl/wdt_counter.sv
// Watchdog counter with selectable power-of-two overflow
`timescale 1ns/10ps
`default_nettype none
module wdt_counter
  import wdt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  wdt_cnt_if.cnt bus
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W:0] span_w;
  logic [CNT_W-1:0] limit_w;
  logic ov_w;

  assign span_w = (CNT_W+1)'(1) << TO_EXP[bus.tsel];
  assign limit_w = CNT_W'(span_w - (CNT_W+1)'(1));
  // Compare with >= so a shorter select takes effect at once
  assign ov_w = bus.enable & bus.tick & (cnt_q >= limit_w);
  assign bus.overflow = ov_w;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || bus.clear) begin
      cnt_q <= '0;
    end else if (bus.enable && bus.tick) begin
      cnt_q <= ov_w ? '0 : cnt_q + CNT_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  clear_zeroes_a: assert property (bus.clear |=> cnt_q == '0)
    else $error("watchdog count not zero after clear");
  ov_at_limit_a: assert property (ov_w |-> cnt_q >= limit_w ##1 cnt_q == '0)
    else $error("overflow not at selected division");
endmodule : wdt_counter
`default_nettype wire

// >>> rtl/wdt_wake_ctrl.sv
// Watchdog, reset flags and sleep wake-up sequencing with a Wishbone slave
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module wdt_wake_ctrl
  import wdt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sub_clk_i,
  input wire logic ext_res_n_i,
  input wire logic [PORTA_W-1:0] porta_i,
  input wire logic [IRQ_W-1:0] irq_req_i,
  input wire logic [IRQ_W-1:0] irq_en_i,
  input wire logic stack_full_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic halt_i,
  input wire logic lvr_event_i,
  input wire logic lvr_key_event_i,
  input wire logic lxt_option_i,
  output logic core_reset_o,
  output logic pc_sp_reset_o,
  output logic resume_o,
  output logic irq_take_o,
  output logic core_run_o,
  output logic sysclk_on_sub_o,
  output logic hxt_en_o,
  output logic lxt_en_o,
  output logic low_internal_rc_en_o,
  output logic sub_clk_en_o
);
  wdt_cnt_if cnt_bus ();
  pm_state_t state_q;
  logic ack_q;
  logic [31:0] rd_q;
  logic [7:0] wdt_ctrl_q;
  logic keep_q, lv_reset_q, lv_key_q, key_rst_q;
  logic to_q, pd_q, hs_stable_q, ls_stable_q;
  logic [PORTA_W-1:0] wake_en_q;
  logic [3:0] mode_q;
  logic [1:0] key_cnt_q;
  logic sub_d_q;
  logic [PORTA_W-1:0] porta_d_q;
  logic ext_d_q;
  logic [IRQ_W-1:0] irq_arm_q;
  logic deep_q, osc_off_q, fast_q;
  logic [10:0] sst_q;
  logic core_rst_q, pc_sp_q, resume_q, irq_take_q;
  logic sub_s;
  logic ext_s;
  logic [PORTA_W-1:0] porta_s;
  sync2 #(.W(1), .RST_VAL(1'b0)) u_sub_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(sub_clk_i),
    .q_o(sub_s)
  );
  sync2 #(.W(1), .RST_VAL(1'b1)) u_res_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(ext_res_n_i),
    .q_o(ext_s)
  );
  sync2 #(.W(PORTA_W), .RST_VAL({PORTA_W{1'b1}})) u_pa_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(porta_i),
    .q_o(porta_s)
  );
  wdt_counter u_cnt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .bus(cnt_bus)
  );
  // Bus decode: read data is caught on request, writes land on the ack edge
  wire req_w = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_w = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = wb_adr_i == WDT_CTRL_OFS;
  wire hit_flag = wb_adr_i == RST_FLAG_OFS;
  wire hit_stat = wb_adr_i == STATUS_OFS;
  wire hit_wake = wb_adr_i == WAKE_EN_OFS;
  wire hit_mode = wb_adr_i == MODE_OFS;
  wire [7:0] flag_rd = {keep_q, 4'h0, lv_reset_q, lv_key_q, key_rst_q};
  wire [7:0] stat_rd = {3'h0, sub_clk_en_o, ls_stable_q, hs_stable_q, pd_q, to_q};
  wire [7:0] rd_w = hit_ctrl ? wdt_ctrl_q :
                    hit_flag ? flag_rd :
                    hit_stat ? stat_rd :
                    hit_wake ? wake_en_q :
                    hit_mode ? {4'h0, mode_q} : 8'h00;
  // Watchdog key decoding
  wire [4:0] key_w = wdt_ctrl_q[7:KEY_LSB];
  wire key_bad = (key_w != KEY_ENABLE) && (key_w != KEY_DISABLE);
  wire wdt_on = key_w == KEY_ENABLE;
  wire lvd_en = mode_q[LVD_EN_BIT];
  wire sub_run = wdt_on | lvd_en | key_bad;
  wire sub_tick = sub_s & ~sub_d_q;
  wire key_rst_ev = key_bad & sub_tick & (key_cnt_q == KEY_RESET_TICKS - 2'h1);
  wire in_run = state_q == PM_RUN;
  wire in_halt = state_q == PM_HALT;
  wire halt_ev = in_run & halt_i;
  wire ov = cnt_bus.overflow;
  // Wake sources seen while halted
  wire ext_low = ~ext_s;
  wire ext_fall = ext_d_q & ~ext_s;
  wire port_fall = |(wake_en_q & porta_d_q & ~porta_s);
  wire [IRQ_W-1:0] irq_new = irq_arm_q & irq_req_i;
  wire irq_wake = |irq_new;
  wire irq_serve = |(irq_new & irq_en_i) & ~stack_full_i;
  wire wake_ev = in_halt & (ext_low | ov | irq_wake | port_fall);
  wire full_rst_ev = ext_fall | key_rst_ev | (ov & ~in_halt) | (in_halt & ext_low);
  wire sst_done = sst_q == SST_CYCLES - 11'h001;
  wire ls_needed = deep_q & lxt_option_i & sub_run;
  // Counter hookup; a clear from the core lands the same edge, so none is lost
  assign cnt_bus.tick = sub_tick;
  assign cnt_bus.enable = wdt_on & sub_run;
  assign cnt_bus.clear = clear_watchdog_instr_i | halt_ev | key_rst_ev | core_rst_q;
  assign cnt_bus.tsel = wdt_ctrl_q[2:0];
  // Sampling flops for edge detection
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sub_d_q <= 1'b0;
      ext_d_q <= 1'b1;
      porta_d_q <= {PORTA_W{1'b1}};
    end else begin
      sub_d_q <= sub_s;
      ext_d_q <= ext_s;
      porta_d_q <= porta_s;
    end
  end

  // Wishbone slave: ack one cycle after the strobe, dropped the next
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0;
    end else begin
      ack_q <= req_w;
      rd_q <= req_w ? {24'h0, rd_w} : 32'h0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wdt_ctrl_q <= WDT_CTRL_RST;
      keep_q <= 1'b0;
      wake_en_q <= '0;
      mode_q <= MODE_RST;
    end else begin
      if (full_rst_ev) begin
        wdt_ctrl_q <= WDT_CTRL_RST;
      end else if (wr_w && hit_ctrl) begin
        wdt_ctrl_q <= wb_dat_i[7:0];
      end
      if (wr_w && hit_flag) begin
        keep_q <= wb_dat_i[SYSCLK_KEEP_BIT];
      end
      if (wr_w && hit_wake) begin
        wake_en_q <= wb_dat_i[PORTA_W-1:0];
      end
      if (wr_w && hit_mode) begin
        mode_q <= wb_dat_i[3:0];
      end
    end
  end

  // Sticky reset flags: hardware set wins over a software zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      key_rst_q <= 1'b0;
      lv_key_q <= 1'b0;
      lv_reset_q <= 1'b0;
    end else begin
      if (key_rst_ev) begin
        key_rst_q <= 1'b1;
      end else if (wr_w && hit_flag && !wb_dat_i[KEY_RESET_BIT]) begin
        key_rst_q <= 1'b0;
      end
      if (lvr_key_event_i) begin
        lv_key_q <= 1'b1;
      end else if (wr_w && hit_flag && !wb_dat_i[LV_KEY_BIT]) begin
        lv_key_q <= 1'b0;
      end
      if (lvr_event_i) begin
        lv_reset_q <= 1'b1;
      end else if (wr_w && hit_flag && !wb_dat_i[LV_RESET_BIT]) begin
        lv_reset_q <= 1'b0;
      end
    end
  end

  // Illegal key delay in sub-clock ticks
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !key_bad) begin
      key_cnt_q <= 2'h0;
    end else if (sub_tick) begin
      key_cnt_q <= key_cnt_q + 2'h1;
    end
  end

  // Power-down and timeout flags
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pd_q <= 1'b0;
      to_q <= 1'b0;
    end else begin
      if (halt_ev) begin
        pd_q <= 1'b1;
      end else if (clear_watchdog_instr_i) begin
        pd_q <= 1'b0;
      end
      if (ov) begin
        to_q <= 1'b1;
      end else if (halt_ev || clear_watchdog_instr_i) begin
        to_q <= 1'b0;
      end
    end
  end

  // Event outputs and system reset, all registered
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      core_rst_q <= 1'b1;
      pc_sp_q <= 1'b0;
      resume_q <= 1'b0;
      irq_take_q <= 1'b0;
    end else begin
      core_rst_q <= full_rst_ev;
      pc_sp_q <= in_halt & ov & ~ext_low;
      resume_q <= in_halt & ~ext_low & ~ov & ((irq_wake & ~irq_serve) | (~irq_wake & port_fall));
      irq_take_q <= in_halt & ~ext_low & ~ov & irq_serve;
    end
  end

  // Power mode sequencing
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= PM_HS_START;
      deep_q <= 1'b1;
      osc_off_q <= 1'b1;
      fast_q <= 1'b0;
      irq_arm_q <= '0;
      sst_q <= 11'h000;
      hs_stable_q <= 1'b0;
      ls_stable_q <= 1'b0;
    end else begin
      case (state_q)
        PM_RUN: begin
          if (halt_ev) begin
            state_q <= PM_HALT;
            deep_q <= ~mode_q[IDLE_EN_BIT] & ~sub_run;
            osc_off_q <= ~(mode_q[IDLE_EN_BIT] & keep_q);
            fast_q <= ~mode_q[IDLE_EN_BIT] & sub_run & mode_q[FAST_WAKE_BIT] & mode_q[HXT_SEL_BIT];
            irq_arm_q <= ~irq_req_i;
            if (!(mode_q[IDLE_EN_BIT] && keep_q)) begin
              hs_stable_q <= 1'b0;
            end
            if (!mode_q[IDLE_EN_BIT] && !sub_run && lxt_option_i) begin
              ls_stable_q <= 1'b0;
            end
          end
        end
        PM_HALT: begin
          sst_q <= 11'h000;
          if (wake_ev) begin
            state_q <= osc_off_q ? PM_HS_START : PM_RUN;
          end
        end
        PM_HS_START: begin
          sst_q <= sst_q + 11'h001;
          if (sst_done) begin
            hs_stable_q <= 1'b1;
            sst_q <= 11'h000;
            fast_q <= 1'b0;
            state_q <= ls_needed ? PM_LS_START : PM_RUN;
          end
        end
        PM_LS_START: begin
          sst_q <= sst_q + 11'h001;
          if (sst_done) begin
            ls_stable_q <= 1'b1;
            deep_q <= 1'b0;
            state_q <= PM_RUN;
          end
        end
        default: begin
          state_q <= PM_RUN;
        end
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign core_reset_o = core_rst_q;
  assign pc_sp_reset_o = pc_sp_q;
  assign resume_o = resume_q;
  assign irq_take_o = irq_take_q;
  // Low crystal runs its start-up in the core, so execution may proceed meanwhile
  assign core_run_o = in_run | (state_q == PM_LS_START) | ((state_q == PM_HS_START) & fast_q);
  // Timers take the system clock; this select switches them too, while the watchdog counts sub ticks
  assign sysclk_on_sub_o = (state_q == PM_HS_START) & fast_q;
  assign hxt_en_o = ~in_halt | ~osc_off_q;
  // High crystal owns the shared start-up timer first
  assign lxt_en_o = lxt_option_i & sub_run & ~((state_q == PM_HS_START) & deep_q);
  assign low_internal_rc_en_o = ~lxt_option_i & sub_run;
  assign sub_clk_en_o = sub_run;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence halt_entry_s;
    in_run && halt_i ##1 state_q == PM_HALT;
  endsequence
  halt_sets_pd_a: assert property (halt_entry_s |-> pd_q && !to_q)
    else $error("power-down flag not set on halt");
  clr_clears_pd_a: assert property (clear_watchdog_instr_i && !halt_ev |=> !pd_q)
    else $error("power-down flag not cleared by clear-watchdog");
  run_ov_reset_a: assert property (ov && in_run |=> core_rst_q && to_q)
    else $error("overflow in run did not reset");
  halt_ov_partial_a: assert property (ov && in_halt && !ext_low |=> pc_sp_q && !core_rst_q && to_q)
    else $error("overflow in sleep not a partial reset");
  key_reset_flag_a: assert property (key_rst_ev |=> key_rst_q && wdt_ctrl_q == WDT_CTRL_RST ##1 key_rst_q)
    else $error("illegal key reset did not set flag");
  key_delay_a: assert property (key_rst_ev |-> key_bad && key_cnt_q == 2'h1 && sub_tick)
    else $error("illegal key reset at wrong tick");
  stable_gate_a: assert property (state_q == PM_HS_START && !fast_q |-> !core_run_o)
    else $error("core ran before oscillator stable");
  sub_stop_a: assert property (key_w == KEY_DISABLE && !lvd_en |-> !sub_clk_en_o && !lxt_en_o)
    else $error("sub clock running with both users off");
  stale_irq_a: assert property (in_halt && !irq_wake && !ext_low && !port_fall && !ov |=> state_q == PM_HALT)
    else $error("woke without a valid source");
  irq_serve_a: assert property (in_halt && irq_serve && !ext_low && !ov |=> irq_take_q && !resume_q)
    else $error("enabled interrupt not taken on wake");
  flag_zero_a: assert property (ack_q && hit_flag && !wb_we_i |-> wb_dat_o[6:3] == 4'h0)
    else $error("reserved flag bits read non-zero");
  wb_ack_once_a: assert property (req_w |=> ack_q ##1 !ack_q)
    else $error("wishbone ack not a single cycle");
endmodule : wdt_wake_ctrl
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the watchdog and wake-up control block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import wdt_pkg::*;
;
  logic ref_clk_i = 0, rst_n_i = 0, sub_clk_i = 0, ext_res_n_i = 1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [PORTA_W-1:0] porta_i = '1;
  logic [IRQ_W-1:0] irq_req_i = '0, irq_en_i = '0;
  logic stack_full_i = 0, clear_watchdog_instr_i = 0, halt_i = 0, lvr_event_i = 0, lvr_key_event_i = 0;
  logic core_reset_o, pc_sp_reset_o, resume_o, irq_take_o, core_run_o;
  logic lxt_option_i = 0;
  logic sysclk_on_sub_o, hxt_en_o, lxt_en_o, low_internal_rc_en_o, sub_clk_en_o;
  int err_total = 0, checked = 0;
  bit seen;
  logic [7:0] rd;
  wdt_wake_ctrl DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sub_clk_i(sub_clk_i),
    .ext_res_n_i(ext_res_n_i), .porta_i(porta_i), .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
    .stack_full_i(stack_full_i), .clear_watchdog_instr_i(clear_watchdog_instr_i), .halt_i(halt_i),
    .lvr_event_i(lvr_event_i), .lvr_key_event_i(lvr_key_event_i),
    .lxt_option_i(lxt_option_i),
    .core_reset_o(core_reset_o), .pc_sp_reset_o(pc_sp_reset_o), .resume_o(resume_o),
    .irq_take_o(irq_take_o), .core_run_o(core_run_o), .sysclk_on_sub_o(sysclk_on_sub_o),
    .hxt_en_o(hxt_en_o), .lxt_en_o(lxt_en_o), .low_internal_rc_en_o(low_internal_rc_en_o),
    .sub_clk_en_o(sub_clk_en_o));
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Sub clock free-runs at four system cycles, phase unrelated to the system clock
  initial begin
    #37;
    forever #100 sub_clk_i = ~sub_clk_i;
  end
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic chk_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val
  task automatic chk_evt(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_evt
  // Classic single cycle; waits for ack without assuming latency
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, dat};
    do begin
      @(posedge ref_clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer
  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [7:0] mask,
                        input logic [7:0] exp);
    wb_xfer(1'b0, adr, 8'h00);
    chk_val(name, exp, rd & mask);
  endtask : rd_chk
  // Watches one output for a bounded number of edges
  task automatic wait_evt(input int sel, input int lim, output bit hit);
    logic v;
    hit = 0;
    for (int n = 0; n < lim && !hit; n++) begin
      @(posedge ref_clk_i);
      case (sel)
        0: v = core_reset_o;
        1: v = pc_sp_reset_o;
        2: v = resume_o;
        3: v = irq_take_o;
        4: v = core_run_o;
        default: v = ~sub_clk_en_o;
      endcase
      if (v === 1'b1) hit = 1;
    end
  endtask : wait_evt
  task automatic strobe(input int which);
    @(posedge ref_clk_i);
    case (which)
      0: halt_i <= 1'b1;
      1: clear_watchdog_instr_i <= 1'b1;
      default: {lvr_event_i, lvr_key_event_i} <= 2'b11;
    endcase
    @(posedge ref_clk_i);
    {halt_i, clear_watchdog_instr_i, lvr_event_i, lvr_key_event_i} <= 4'h0;
  endtask : strobe
  task automatic run_wait;
    wait_evt(4, 3000, seen);
    chk_evt("core running", 1, seen);
  endtask : run_wait
  // Idle with the system clock kept, so wakes show as pulses
  task automatic halt_idle;
    wb_xfer(1'b1, MODE_OFS, 8'h05);
    wb_xfer(1'b1, RST_FLAG_OFS, 8'h80);
    strobe(0);
  endtask : halt_idle
  task automatic t_reset_regs;
    rd_chk("control", WDT_CTRL_OFS, 8'hFF, 8'h53);
    rd_chk("flag reg", RST_FLAG_OFS, 8'h7B, 8'h00);
    rd_chk("status pd to", STATUS_OFS, 8'h03, 8'h00);
    wb_xfer(1'b1, 8'h40, 8'hA5);
    rd_chk("unmapped", 8'h40, 8'hFF, 8'h00);
    $display("test reset_regs done");
  endtask : t_reset_regs
  task automatic t_flags;
    strobe(2);
    rd_chk("lv flags", RST_FLAG_OFS, 8'h7F, 8'h06);
    wb_xfer(1'b1, RST_FLAG_OFS, 8'h00);
    rd_chk("lv cleared", RST_FLAG_OFS, 8'h7F, 8'h00);
    // Writing ones sets nothing and the unused bits stay zero
    wb_xfer(1'b1, RST_FLAG_OFS, 8'h7F);
    rd_chk("ones written", RST_FLAG_OFS, 8'h7F, 8'h00);
    $display("test flags done");
  endtask : t_flags
  task automatic t_porta_wake;
    wb_xfer(1'b1, WAKE_EN_OFS, 8'h04);
    halt_idle();
    rd_chk("pd set", STATUS_OFS, 8'h02, 8'h02);
    porta_i[1] <= 1'b0;
    wait_evt(2, 20, seen);
    chk_evt("disabled pin", 0, seen);
    porta_i[2] <= 1'b0;
    wait_evt(2, 20, seen);
    chk_evt("port wake", 1, seen);
    porta_i <= '1;
    run_wait();
    strobe(1);
    rd_chk("pd cleared", STATUS_OFS, 8'h02, 8'h00);
    $display("test porta_wake done");
  endtask : t_porta_wake
  task automatic t_irq_wake;
    for (int k = 0; k < 3; k++) begin
      irq_en_i <= (k == 0) ? 4'h0 : 4'h4;
      stack_full_i <= (k == 1);
      halt_idle();
      irq_req_i <= 4'h4;
      wait_evt(k == 2 ? 3 : 2, 20, seen);
      chk_evt("irq wake", 1, seen);
      chk_evt("other pulse", 0, k == 2 ? resume_o : irq_take_o);
      irq_req_i <= 4'h0;
      run_wait();
    end
    $display("test irq_wake done");
  endtask : t_irq_wake
  task automatic t_pending_irq;
    irq_en_i <= 4'h2;
    irq_req_i <= 4'h2;
    halt_idle();
    wait_evt(3, 30, seen);
    chk_evt("pending wake", 0, seen);
    porta_i[2] <= 1'b0;
    wait_evt(2, 20, seen);
    chk_evt("port wake", 1, seen);
    {porta_i, irq_req_i} <= {8'hFF, 4'h0};
    run_wait();
    $display("test pending_irq done");
  endtask : t_pending_irq
  task automatic t_ext_reset;
    halt_idle();
    ext_res_n_i <= 1'b0;
    wait_evt(0, 12, seen);
    chk_evt("ext reset", 1, seen);
    ext_res_n_i <= 1'b1;
    run_wait();
    $display("test ext_reset done");
  endtask : t_ext_reset
  task automatic t_illegal_key;
    wb_xfer(1'b1, WDT_CTRL_OFS, 8'h03);
    wait_evt(0, 40, seen);
    chk_evt("key reset", 1, seen);
    rd_chk("key flag", RST_FLAG_OFS, 8'h01, 8'h01);
    rd_chk("control reload", WDT_CTRL_OFS, 8'hFF, 8'h53);
    run_wait();
    rd_chk("flag kept", RST_FLAG_OFS, 8'h01, 8'h01);
    wb_xfer(1'b1, RST_FLAG_OFS, 8'h00);
    rd_chk("flag cleared", RST_FLAG_OFS, 8'h01, 8'h00);
    $display("test illegal_key done");
  endtask : t_illegal_key
  task automatic t_disable;
    wb_xfer(1'b1, WDT_CTRL_OFS, 8'hA8);
    wait_evt(5, 10, seen);
    chk_evt("sub clock off", 1, seen);
    wait_evt(0, 1300, seen);
    chk_evt("disabled no reset", 0, seen);
    wb_xfer(1'b1, WDT_CTRL_OFS, 8'h53);
    @(posedge ref_clk_i);
    chk_evt("sub clock on", 1, sub_clk_en_o);
    $display("test disable done");
  endtask : t_disable
  // Shortest select: 2^8 sub ticks of four system cycles each
  task automatic t_run_overflow;
    wb_xfer(1'b1, WDT_CTRL_OFS, 8'h50);
    strobe(1);
    wait_evt(0, 900, seen);
    chk_evt("early overflow", 0, seen);
    wait_evt(0, 300, seen);
    chk_evt("run overflow", 1, seen);
    rd_chk("timeout flag", STATUS_OFS, 8'h01, 8'h01);
    rd_chk("control reload", WDT_CTRL_OFS, 8'hFF, 8'h53);
    run_wait();
    $display("test run_overflow done");
  endtask : t_run_overflow
  task automatic t_sleep_overflow;
    wb_xfer(1'b1, WDT_CTRL_OFS, 8'h50);
    halt_idle();
    wait_evt(1, 1300, seen);
    chk_evt("sleep overflow", 1, seen);
    chk_evt("no full reset", 0, core_reset_o);
    rd_chk("timeout pd", STATUS_OFS, 8'h03, 8'h03);
    wb_xfer(1'b1, WDT_CTRL_OFS, 8'h53);
    strobe(1);
    rd_chk("flags cleared", STATUS_OFS, 8'h03, 8'h00);
    $display("test sleep_overflow done");
  endtask : t_sleep_overflow
  // Sleep with the sub clock running and fast wake: the core restarts on the sub clock
  task automatic t_fast_wake;
    wb_xfer(1'b1, MODE_OFS, 8'h06);
    strobe(0);
    @(posedge ref_clk_i);
    chk_evt("high crystal off", 0, hxt_en_o);
    porta_i[2] <= 1'b0;
    wait_evt(2, 20, seen);
    chk_evt("fast port wake", 1, seen);
    chk_evt("system on sub", 1, sysclk_on_sub_o);
    chk_evt("core runs early", 1, core_run_o);
    porta_i <= '1;
    repeat (1030) @(posedge ref_clk_i);
    chk_evt("back on crystal", 0, sysclk_on_sub_o);
    chk_evt("high crystal on", 1, hxt_en_o);
    $display("test fast_wake done");
  endtask : t_fast_wake
  // Reset in mid-run with the sub clock taken from the low crystal
  task automatic t_lxt_start;
    lxt_option_i <= 1'b1;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk_evt("reset held", 1, core_reset_o);
    rst_n_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    chk_evt("lxt waits", 0, lxt_en_o);
    chk_evt("low_internal_rc off", 0, low_internal_rc_en_o);
    chk_evt("no early run", 0, core_run_o);
    run_wait();
    rd_chk("hs before ls", STATUS_OFS, 8'h0C, 8'h04);
    chk_evt("lxt starts", 1, lxt_en_o);
    repeat (1100) @(posedge ref_clk_i);
    rd_chk("ls stable", STATUS_OFS, 8'h0C, 8'h0C);
    $display("test lxt_start done");
  endtask : t_lxt_start
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset_regs();
    t_flags();
    run_wait();
    t_porta_wake();
    t_irq_wake();
    t_pending_irq();
    t_ext_reset();
    t_illegal_key();
    t_disable();
    t_run_overflow();
    t_sleep_overflow();
    t_fast_wake();
    t_lxt_start();
    complete_run();
  end
  // Tests need roughly 8000 cycles; cut off well after that
  initial begin
    #(80000 * 50);
    err_total++;
    $display("MISMATCH run time expected end seen timeout");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
